// File: plc_flags_pkg.sv
// package: constants shared by the special status flag bank
package plc_flags_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned TICK_MS         = 50;                          // shortest relay half period
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;     // 1,000,000 cycles
    localparam int unsigned SCAN_LIMIT_MS   = 200;
    localparam int unsigned SCAN_LIMIT_TICKS = SCAN_LIMIT_MS / TICK_MS;    // 4 ticks of 50 ms
    // register bus word map (16-bit words)
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_RELAYS  = 4'h1;
    localparam logic [3:0] ADDR_DETAIL  = 4'h2;
    // field positions in the status word
    localparam int unsigned BIT_PROG_FAULT   = 0;
    localparam int unsigned BIT_SCAN_OVERRUN = 1;
    localparam int unsigned BIT_CONST_ZERO   = 2;
    localparam int unsigned BIT_CONST_ONE    = 3;
    localparam int unsigned BIT_CARRY        = 4;
    localparam int unsigned BIT_INSTR_FAULT  = 5;
    localparam int unsigned BIT_BAD_OPCODE   = 6;
    localparam int unsigned BIT_BOUND        = 7;
    localparam int unsigned BIT_DIVIDE       = 8;
    localparam int unsigned BIT_DECIMAL      = 9;
    localparam int unsigned BIT_TABLE        = 10;
    localparam int unsigned BIT_ENCODE       = 11;
    // alarm positions in the detail fault word
    localparam int unsigned DET_BOUND   = 0;
    localparam int unsigned DET_DIVIDE  = 1;
    localparam int unsigned DET_DECIMAL = 2;
    localparam int unsigned DET_TABLE   = 3;
    localparam int unsigned DET_ENCODE  = 4;
    localparam int unsigned DET_PROG    = 8;
    // reset values
    localparam logic [15:0] STATUS_RESET = 16'h0008;
    localparam logic [7:0]  RELAYS_RESET = 8'h00;
endpackage

// File: tick_divider.sv
// module: divider that emits a one-cycle tick every DIVIDE cycles
`timescale 1ns/1ps
module tick_divider #(
    parameter int unsigned DIVIDE = 1000000
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic restart,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;

    // count up, pulse after the last count, restart realigns the phase
    always_comb begin
        next_state      = state;
        next_state.tick = 1'b0;
        if (restart) begin
            next_state.count = 32'h0;
        end else if (state.count == 32'(DIVIDE - 1)) begin
            next_state.count = 32'h0;
            next_state.tick  = 1'b1;
        end else begin
            next_state.count = state.count + 32'h1;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule // tick_divider

// File: plc_special_status_flags.sv
// module: bank of special status flags, timing relays and alarms of the controller cpu
`timescale 1ns/1ps
// What this block does
// - A scan longer than 200 ms sets the scan overrun flag as a fatal error.
// - Entering the program error state sets the program fault flag and its bit in the detail word.
// - Four fast relays of 0.1, 0.2, 0.4 and 0.8 s period run off for half and on for half.
// - Four slow relays of 1, 2, 4 and 8 s period run off for half and on for half.
// - A carry bit is read and updated by carry instructions.
// - A failing instruction sets the instruction fault bit with its alarm in the detail word.
// - An undefined instruction sets the bad opcode flag as a fatal error.
// - An out-of-range indirect operand sets the bound alarm and execution goes on.
// - A failed division sets the divide alarm and execution goes on.
// - A bad BCD digit sets the decimal alarm and execution goes on.
// - A bad table size sets the table alarm and execution goes on.
// - A failed encode sets the encode alarm and execution goes on.
// - Fatal flags are set only one cycle after entry to error mode, never while the program runs.
// - The program may clear the carry bit, the instruction fault bit and every alarm by writing zero.
// - All other status bits ignore program writes and follow the block's own logic.
module plc_special_status_flags #(
    parameter int unsigned TICK_DIV = plc_flags_pkg::TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // cpu mode and scan events
    input  wire logic        run_start,
    input  wire logic        scan_start,
    input  wire logic        scan_active,
    input  wire logic        prog_fault_event,
    input  wire logic        bad_opcode_event,
    // instruction events
    input  wire logic        carry_write,
    input  wire logic        carry_value,
    input  wire logic        bound_event,
    input  wire logic        divide_event,
    input  wire logic        decimal_event,
    input  wire logic        table_event,
    input  wire logic        encode_event,
    // flag outputs
    output logic             error_mode,
    output logic      [7:0]  tick_relays,
    output logic             carry_bit,
    output logic             instr_fault_bit,
    output logic      [15:0] detail_fault_word
);
    typedef enum logic [1:0] {MODE_IDLE, MODE_RUN, MODE_ERROR} cpu_mode_t;

    // status word, address 0
    //   bit 0  program fault, fatal, shown in error mode
    //   bit 1  scan overrun, fatal, shown in error mode
    //   bit 2  constant zero
    //   bit 3  constant one
    //   bit 4  carry, clearable
    //   bit 5  instruction fault, clearable
    //   bit 6  bad opcode, fatal, shown in error mode
    //   bit 7  bound alarm, clearable
    //   bit 8  divide alarm, clearable
    //   bit 9  decimal alarm, clearable
    //   bit 10 table alarm, clearable
    //   bit 11 encode alarm, clearable
    //   bits 15..12 read zero
    // relay word, address 1
    //   bits 3..0 fast relays of 0.1, 0.2, 0.4 and 0.8 s
    //   bits 7..4 slow relays of 1, 2, 4 and 8 s
    //   bits 15..8 read zero
    // detail word, address 2
    //   bits 4..0 copies of the five alarms
    //   bit 8 program fault
    //   other bits read zero
    // write rules
    //   only address 0 takes writes
    //   a zero clears a clearable bit, a one keeps it
    //   an event in the same cycle as a clear wins
    //   a carry load in the same cycle as a clear wins
    // constants
    //   bits 2 and 3 are fixed and ignore writes
    // read timing
    //   data stand one cycle after the strobe
    //   all other cycles the port reads zero
    // mode sequence
    //   idle until run start
    //   run until the first fatal cause
    //   error until reset, fatal flags appear one cycle after entry
    //   events other than run start and carry loads are taken only in run mode
    // event inputs
    //   every event input is a one-cycle pulse
    //   a pulse outside run mode is dropped, except a run start or a carry load
    //   any alarm also raises the instruction fault bit
    //   a carry load takes carry_value in the same cycle
    // time base
    //   one tick every TICK_DIV cycles, 50 ms at the default
    //   run start realigns the tick and clears every relay
    //   relays keep running in idle and error modes
    // scan watch
    //   counts ticks while a scan is active
    //   a count above four ticks is a fatal overrun
    //   resolution is one tick, so the trip lies between 200 and 250 ms
    //   the count saturates so a stalled scan cannot wrap

    typedef struct packed {
        cpu_mode_t   mode;
        logic [7:0]  phase;          // 50 ms tick count, wraps after 256 ticks
        logic [2:0]  slow_div;       // five 100 ms steps make one 0.5 s step
        logic [3:0]  slow_phase;     // 0.5 s steps inside the 8 s frame
        logic [7:0]  relays;
        logic [3:0]  scan_ticks;
        logic        fatal_scan;     // pending fatal causes, shown only in error mode
        logic        fatal_opcode;
        logic        fatal_prog;
        logic        prog_fault_flag;
        logic        scan_overrun_flag;
        logic        bad_opcode_flag;
        logic        carry_bit;
        logic        instr_fault_bit;
        logic [4:0]  alarms;         // bound, divide, decimal, table, encode
        logic [15:0] rdata;
    } flags_state_t;

    flags_state_t state;
    flags_state_t next_state;
    logic         tick;
    logic [15:0]  status_word;
    logic [15:0]  detail_word;
    logic [4:0]   alarm_events;
    logic         status_wr;

    // 50 ms time base, realigned at run start
    tick_divider #(
        .DIVIDE (TICK_DIV)
    ) u_tick (
        .sys_clk (sys_clk),
        .reset   (reset),
        .restart (run_start),
        .tick    (tick)
    );

    assign alarm_events = {encode_event, table_event, decimal_event, divide_event, bound_event};
    assign status_wr    = reg_write && (reg_addr == plc_flags_pkg::ADDR_STATUS);

    // assemble the status and detail words from state
    always_comb begin
        status_word = 16'h0000;
        status_word[plc_flags_pkg::BIT_PROG_FAULT]   = state.prog_fault_flag;
        status_word[plc_flags_pkg::BIT_SCAN_OVERRUN] = state.scan_overrun_flag;
        status_word[plc_flags_pkg::BIT_CONST_ZERO]   = 1'b0;
        status_word[plc_flags_pkg::BIT_CONST_ONE]    = 1'b1;
        status_word[plc_flags_pkg::BIT_CARRY]        = state.carry_bit;
        status_word[plc_flags_pkg::BIT_INSTR_FAULT]  = state.instr_fault_bit;
        status_word[plc_flags_pkg::BIT_BAD_OPCODE]   = state.bad_opcode_flag;
        status_word[plc_flags_pkg::BIT_BOUND]        = state.alarms[0];
        status_word[plc_flags_pkg::BIT_DIVIDE]       = state.alarms[1];
        status_word[plc_flags_pkg::BIT_DECIMAL]      = state.alarms[2];
        status_word[plc_flags_pkg::BIT_TABLE]        = state.alarms[3];
        status_word[plc_flags_pkg::BIT_ENCODE]       = state.alarms[4];

        // detail word: alarms and the program fault
        detail_word = 16'h0000;
        detail_word[plc_flags_pkg::DET_BOUND]   = state.alarms[0];
        detail_word[plc_flags_pkg::DET_DIVIDE]  = state.alarms[1];
        detail_word[plc_flags_pkg::DET_DECIMAL] = state.alarms[2];
        detail_word[plc_flags_pkg::DET_TABLE]   = state.alarms[3];
        detail_word[plc_flags_pkg::DET_ENCODE]  = state.alarms[4];
        detail_word[plc_flags_pkg::DET_PROG]    = state.prog_fault_flag;
    end

    // next state: mode, relays, scan watch, flags and read data
    always_comb begin
        next_state = state;
        // relay phase counters advance on each 50 ms tick
        if (tick) begin
            next_state.phase = state.phase + 8'h1;
            if (state.phase[0]) begin
                if (state.slow_div == 3'h4) begin
                    next_state.slow_div   = 3'h0;
                    next_state.slow_phase = state.slow_phase + 4'h1;
                end else begin
                    next_state.slow_div = state.slow_div + 3'h1;
                end
            end
        end

        // relay k is the high bit of its half-period count
        next_state.relays[3:0] = next_state.phase[3:0];
        next_state.relays[7:4] = next_state.slow_phase[3:0];

        // scan duration in 50 ms ticks, restarted by each scan
        if (scan_start) begin
            next_state.scan_ticks = 4'h0;
        end else if (scan_active && tick && state.scan_ticks != 4'hF) begin
            next_state.scan_ticks = state.scan_ticks + 4'h1;
        end

        // mode sequence: idle, run, error
        case (state.mode)
            MODE_IDLE: begin
                if (run_start) begin
                    next_state.mode = MODE_RUN;
                end
            end

            MODE_RUN: begin
                // fatal causes are latched but kept hidden until error mode
                if (scan_active && next_state.scan_ticks > 4'(plc_flags_pkg::SCAN_LIMIT_TICKS)) begin
                    next_state.fatal_scan = 1'b1;
                end

                if (bad_opcode_event) begin
                    next_state.fatal_opcode = 1'b1;
                end

                if (prog_fault_event) begin
                    next_state.fatal_prog = 1'b1;
                end

                if (next_state.fatal_scan || next_state.fatal_opcode || next_state.fatal_prog) begin
                    next_state.mode = MODE_ERROR;
                end
            end

            MODE_ERROR: begin
                // flags appear only here, when the program is stopped
                next_state.scan_overrun_flag = state.fatal_scan;
                next_state.bad_opcode_flag   = state.fatal_opcode;
                next_state.prog_fault_flag   = state.fatal_prog;
            end

            default: begin
                next_state.mode = MODE_IDLE;
            end
        endcase

        // every relay starts its off half at run start
        if (run_start) begin
            next_state.phase      = 8'h0;
            next_state.slow_div   = 3'h0;
            next_state.slow_phase = 4'h0;
            next_state.relays     = plc_flags_pkg::RELAYS_RESET;
            next_state.scan_ticks = 4'h0;
        end

        // program writes clear only the clearable bits; set wins over clear
        if (status_wr) begin
            if (!reg_wdata[plc_flags_pkg::BIT_CARRY]) begin
                next_state.carry_bit = 1'b0;
            end
            if (!reg_wdata[plc_flags_pkg::BIT_INSTR_FAULT]) begin
                next_state.instr_fault_bit = 1'b0;
            end
            next_state.alarms = state.alarms & reg_wdata[plc_flags_pkg::BIT_ENCODE:plc_flags_pkg::BIT_BOUND];
        end

        if (carry_write) begin
            next_state.carry_bit = carry_value;
        end

        // alarms set in run mode and execution goes on
        if (state.mode == MODE_RUN) begin
            next_state.alarms = next_state.alarms | alarm_events;
            if (|alarm_events) begin
                next_state.instr_fault_bit = 1'b1;
            end
        end

        // read data one cycle after the strobe; other words read zero
        next_state.rdata = 16'h0000;
        if (reg_read) begin
            if (reg_addr == plc_flags_pkg::ADDR_STATUS) begin
                next_state.rdata = status_word;
            end else if (reg_addr == plc_flags_pkg::ADDR_RELAYS) begin
                next_state.rdata = {8'h00, state.relays};
            end else if (reg_addr == plc_flags_pkg::ADDR_DETAIL) begin
                next_state.rdata = detail_word;
            end else begin
                next_state.rdata = 16'h0000;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state        <= '0;
            state.mode   <= MODE_IDLE;
            state.relays <= plc_flags_pkg::RELAYS_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata         = state.rdata;
    assign error_mode        = (state.mode == MODE_ERROR);
    assign tick_relays       = state.relays;
    assign carry_bit         = state.carry_bit;
    assign instr_fault_bit   = state.instr_fault_bit;
    assign detail_fault_word = detail_word;
endmodule // plc_special_status_flags

// File: plc_flags_assertions.sv
// checker: concurrent assertions on the special status flag bank ports
`timescale 1ns/1ps
module plc_flags_checker #(
    parameter int unsigned TICK_DIV = 10
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        run_start,
    input wire logic        bound_event,
    input wire logic        prog_fault_event,
    input wire logic        carry_write,
    input wire logic        carry_value,
    input wire logic        error_mode,
    input wire logic [7:0]  tick_relays,
    input wire logic        carry_bit,
    input wire logic        instr_fault_bit,
    input wire logic [15:0] detail_fault_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // run mode seen since reset
    logic running;
    always_ff @(posedge sys_clk) running <= reset ? 1'b0 : (running | run_start);
    // fatal cause taken in run mode, then error mode with its flag
    sequence fatal_in;
        running && !error_mode && prog_fault_event;
    endsequence
    sequence fatal_out;
        error_mode && detail_fault_word[plc_flags_pkg::DET_PROG];
    endsequence
    fatal_path_a: assert property (fatal_in |-> ##[1:3] fatal_out) else $error("fatal flag late");
    fatal_hidden_a: assert property (!error_mode |-> !detail_fault_word[plc_flags_pkg::DET_PROG]) else $error("fatal flag in run");
    mode_sticky_a: assert property (error_mode |=> error_mode) else $error("error mode left");
    bound_set_a: assert property (running && !error_mode && bound_event |=> detail_fault_word[plc_flags_pkg::DET_BOUND] && instr_fault_bit)
        else $error("bound alarm missed");
    carry_load_a: assert property (carry_write |=> carry_bit == $past(carry_value)) else $error("carry not loaded");
    relay_off_a: assert property (run_start |=> tick_relays == 8'h00) else $error("relays not off");
    relay_hold_a: assert property ($changed(tick_relays[0]) |=> ($stable(tick_relays[0]) || $past(run_start)) [*8])
        else $error("fast relay toggled early");
    read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data not idle");
endmodule // plc_flags_checker

bind plc_special_status_flags plc_flags_checker #(.TICK_DIV(TICK_DIV)) u_plc_flags_checker (
    .sys_clk(sys_clk), .reset(reset), .reg_read(reg_read), .reg_rdata(reg_rdata), .run_start(run_start),
    .bound_event(bound_event), .prog_fault_event(prog_fault_event), .carry_write(carry_write),
    .carry_value(carry_value), .error_mode(error_mode), .tick_relays(tick_relays), .carry_bit(carry_bit),
    .instr_fault_bit(instr_fault_bit), .detail_fault_word(detail_fault_word));

// File: tb_plc_special_status_flags.sv
// testbench: directed scenarios for the special status flag bank
`timescale 1ns/1ps
module tb_plc_special_status_flags;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [9:0]  ev = 10'h000; // alarms 0..4, prog 5, opcode 6, run 7, scan 8, carry 9
    logic        scan_active = 1'b0;
    logic        carry_value = 1'b0;
    logic [15:0] reg_rdata;
    logic        error_mode;
    logic [7:0]  tick_relays;
    logic        carry_bit;
    logic        instr_fault_bit;
    logic [15:0] detail_fault_word;
    logic [15:0] d;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    plc_special_status_flags #(.TICK_DIV(10)) u_plc_special_status_flags (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .run_start(ev[7]), .scan_start(ev[8]),
        .scan_active(scan_active), .prog_fault_event(ev[5]), .bad_opcode_event(ev[6]), .carry_write(ev[9]),
        .carry_value(carry_value), .bound_event(ev[0]), .divide_event(ev[1]), .decimal_event(ev[2]),
        .table_event(ev[3]), .encode_event(ev[4]), .error_mode(error_mode), .tick_relays(tick_relays),
        .carry_bit(carry_bit), .instr_fault_bit(instr_fault_bit), .detail_fault_word(detail_fault_word));

    // 50 ns clock and a hang limit
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one write cycle, one read cycle with data in the next cycle
    task automatic wr(logic [3:0] a, logic [15:0] v);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pulse(int i);
        @(posedge sys_clk);
        ev <= 10'h001 << i;
        @(posedge sys_clk);
        ev <= 10'h000;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
    endtask

    // reset values, ignored writes, unmapped read
    task automatic t_idle();
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("status", 16'h0008, d);
        wr(plc_flags_pkg::ADDR_STATUS, 16'hFFFF);
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("status_wr", 16'h0008, d);
        rd(4'hF);
        chk("unmapped", 16'h0000, d);
    endtask
    // relays sampled mid tick; half periods of 1,2,4,8,10,20,40,80 ticks
    task automatic t_relays(int n);
        logic [7:0] e;
        pulse(7);
        rd(plc_flags_pkg::ADDR_RELAYS);
        chk("relay_word", 16'h0000, d);
        repeat (3) @(posedge sys_clk);
        for (int t = 0; t <= n; t++) begin
            #1;
            for (int k = 0; k < 8; k++) e[k] = ((t / (k < 4 ? 1 << k : 10 << (k - 4))) % 2) == 1;
            chk("relays", {8'h00, e}, {8'h00, tick_relays});
            repeat (10) @(posedge sys_clk);
        end
    endtask
    task automatic t_carry();
        @(posedge sys_clk);
        carry_value <= 1'b1;
        pulse(9);
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("carry", 16'h0018, d);
        chk("carry_bit", 16'h0001, {15'h0000, carry_bit});
        wr(plc_flags_pkg::ADDR_STATUS, 16'hFFEF);
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("carry_clr", 16'h0008, d);
        chk("carry_bit_clr", 16'h0000, {15'h0000, carry_bit});
    endtask
    // each alarm sets its bit and the fault bit, then is cleared
    task automatic t_alarms();
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            rd(plc_flags_pkg::ADDR_STATUS);
            chk("alarm", 16'h0028 | (16'h0080 << i), d);
            chk("detail", 16'h0001 << i, detail_fault_word & (16'h0001 << i));
            chk("instr_fault", 16'h0001, {15'h0000, instr_fault_bit});
            rd(plc_flags_pkg::ADDR_DETAIL);
            chk("detail_word", 16'h0001 << i, d);
            wr(plc_flags_pkg::ADDR_STATUS, ~(16'h0020 | (16'h0080 << i)));
            rd(plc_flags_pkg::ADDR_STATUS);
            chk("alarm_clr", 16'h0008, d);
            chk("instr_clr", 16'h0000, {15'h0000, instr_fault_bit});
        end
    endtask
    // four ticks of scan are allowed, six are not
    task automatic t_scan();
        do_reset();
        pulse(7);
        pulse(8);
        scan_active <= 1'b1;
        repeat (40) @(posedge sys_clk);
        scan_active <= 1'b0;
        #1 chk("short_scan", 16'h0000, {15'h0000, error_mode});
        pulse(8);
        scan_active <= 1'b1;
        repeat (60) @(posedge sys_clk);
        scan_active <= 1'b0;
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("long_scan", 16'h000A, d);
    endtask
    task automatic t_fatal(int i, logic [15:0] es, logic [15:0] ed);
        do_reset();
        pulse(7);
        pulse(i);
        repeat (3) @(posedge sys_clk);
        rd(plc_flags_pkg::ADDR_STATUS);
        chk("fatal", es, d);
        chk("fatal_detail", ed, detail_fault_word);
        chk("err_mode", 16'h0001, {15'h0000, error_mode});
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        t_idle();
        t_relays(170);
        t_relays(5);
        t_carry();
        t_alarms();
        t_scan();
        t_fatal(5, 16'h0009, 16'h0100);
        t_fatal(6, 16'h0048, 16'h0000);
        results();
    end
endmodule // tb_plc_special_status_flags
